//--- cat_pkg.sv
// constants for the cursor address tracker
package cat_pkg;
    // address and tracking field widths
    localparam int UNITS_W    = 4;
    localparam int TENS_W     = 3;
    localparam int ROW_W      = 3;
    localparam int MOD_W      = 2;
    localparam int LOAD_W     = 7;
    localparam int SCAN_W     = 4;
    // field limits and encodings
    localparam logic [UNITS_W-1:0] UNITS_MAX   = 4'h9;
    localparam logic [TENS_W-1:0]  TENS_MAX    = 3'h7;
    localparam logic [ROW_W-1:0]   ROW_MAX     = 3'h7;
    localparam logic [MOD_W-1:0]   MOD_LAST    = 2'h2;
    localparam logic [MOD_W-1:0]   MOD_BAD     = 2'h3;
    localparam logic [SCAN_W-1:0]  CURSOR_SCAN = 4'h8;
    // reset values: column 0, row 0, module 0
    localparam logic [UNITS_W-1:0] UNITS_RST   = 4'h0;
    localparam logic [TENS_W-1:0]  TENS_RST    = 3'h0;
    localparam logic [ROW_W-1:0]   ROW_RST     = 3'h0;
    localparam logic [MOD_W-1:0]   MOD_RST     = 2'h0;
    // load word field positions
    localparam int LD_UNITS_LSB = 0;
    localparam int LD_TENS_LSB  = 4;
    localparam int LD_ROW_LSB   = 0;
    localparam int LD_MOD_LSB   = 3;
    // event vector bit positions
    localparam int EV_FWD   = 0;
    localparam int EV_BACK  = 1;
    localparam int EV_UP    = 2;
    localparam int EV_ADV   = 3;
    localparam int EV_HOME  = 4;
    localparam int EV_XLD   = 5;
    localparam int EV_YLD   = 6;
    localparam int EV_ACC   = 7;
    localparam int EV_DOWN  = 8;
    localparam int EV_LF    = 9;
    localparam int EV_SHIFT = 10;
    localparam int EV_W     = 11;
    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CHAR_TIME_NS    = 639;
    localparam int FIX_DELAY_NS    = 300;
    localparam int FIX_DELAY_CYC   = (FIX_DELAY_NS / CLK_PERIOD_NS < 1) ?
                                     1 : FIX_DELAY_NS / CLK_PERIOD_NS;
    localparam int FIX_CNT_W       = 3;
    localparam logic [FIX_CNT_W-1:0] FIX_LIMIT =
        FIX_CNT_W'(FIX_DELAY_CYC);
endpackage

//--- cat_tracker.sv
// cursor address counter, tracking counter and position compare
// Operation
// - column counts 0-79 up or down
// - row counter picks one of eight rows
// - module counter counts modulo three
// - tracking counter advances per shift pulse
// - tracking spans one module: 80 columns, 8 rows
// - column match gated by compare enable
// - position match needs column and row equal
// - memory access steps cursor forward automatically
// - line advance from advance pin, down, feed, auto feed
// - units digit above nine forced to zero
// - column wrap from 79 carries row up
// - column zero down count decrements row
// - row wrap steps module up or down
// - module state three forced to zero
// - column load: upper tens, lower units
// - row load: bits zero-two row, three-four module
// - final row flag at module two row seven
// - cursor pulse in scan line eight
`timescale 1ns/1ps
`default_nettype none
module cat_tracker (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic                      cursor_step_forward_n,
    input  wire logic                      cursor_step_back_n,
    input  wire logic                      cursor_step_up_n,
    input  wire logic                      line_advance_n,
    input  wire logic                      home,
    input  wire logic                      column_load_strobe_n,
    input  wire logic                      row_load_strobe_n,
    input  wire logic [cat_pkg::LOAD_W-1:0] load_data,
    input  wire logic                      mem_access,
    input  wire logic                      cursor_down,
    input  wire logic                      line_feed,
    input  wire logic                      auto_lf_mode,
    input  wire logic                      mem_shift,
    input  wire logic                      compare_gate,
    input  wire logic [cat_pkg::SCAN_W-1:0] scan_line,
    output logic [cat_pkg::UNITS_W-1:0]    addr_units_q,
    output logic [cat_pkg::TENS_W-1:0]     addr_tens_q,
    output logic [cat_pkg::ROW_W-1:0]      addr_row_q,
    output logic [cat_pkg::MOD_W-1:0]      addr_module_q,
    output logic [cat_pkg::UNITS_W-1:0]    trk_units_q,
    output logic [cat_pkg::TENS_W-1:0]     trk_tens_q,
    output logic [cat_pkg::ROW_W-1:0]      trk_row_q,
    output logic                           column_match_q,
    output logic                           position_match_q,
    output logic                           cursor_q,
    output logic                           final_row_flag_q,
    output logic                           row_carry_up_q,
    output logic                           line_advance_pulse_q
);
    // column index 0-79 from the two column fields
    function automatic logic [6:0] col_index(
        input logic [cat_pkg::TENS_W-1:0]  tens,
        input logic [cat_pkg::UNITS_W-1:0] units);
        col_index = 7'({3'h0, tens} * 7'h0a) + {3'h0, units};
    endfunction

    // all pins pass two flops before use
    logic [cat_pkg::EV_W-1:0]   ev_raw;
    logic [cat_pkg::EV_W-1:0]   ev_s1_q;
    logic [cat_pkg::EV_W-1:0]   ev_s2_q;
    logic [cat_pkg::EV_W-1:0]   ev_s3_q;
    logic [cat_pkg::EV_W-1:0]   ev;
    logic [cat_pkg::LOAD_W-1:0] ld_s1_q;
    logic [cat_pkg::LOAD_W-1:0] ld_s2_q;
    logic [cat_pkg::SCAN_W-1:0] scan_s1_q;
    logic [cat_pkg::SCAN_W-1:0] scan_s2_q;
    logic [1:0]                 lvl_s1_q;
    logic [1:0]                 lvl_s2_q;
    logic                       auto_lf;
    logic                       gate_ok;

    assign ev_raw = {mem_shift, line_feed, cursor_down, mem_access,
                     ~row_load_strobe_n, ~column_load_strobe_n, home,
                     ~line_advance_n, ~cursor_step_up_n,
                     ~cursor_step_back_n, ~cursor_step_forward_n};

    // two-stage synchronisers plus an edge history stage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ev_s1_q   <= '0;
            ev_s2_q   <= '0;
            ev_s3_q   <= '0;
            ld_s1_q   <= '0;
            ld_s2_q   <= '0;
            scan_s1_q <= '0;
            scan_s2_q <= '0;
            lvl_s1_q  <= '0;
            lvl_s2_q  <= '0;
        end else begin
            ev_s1_q   <= ev_raw;
            ev_s2_q   <= ev_s1_q;
            ev_s3_q   <= ev_s2_q;
            ld_s1_q   <= load_data;
            ld_s2_q   <= ld_s1_q;
            scan_s1_q <= scan_line;
            scan_s2_q <= scan_s1_q;
            lvl_s1_q  <= {auto_lf_mode, compare_gate};
            lvl_s2_q  <= lvl_s1_q;
        end
    end

    // one-cycle event on each leading edge
    assign ev      = ev_s2_q & ~ev_s3_q;
    assign gate_ok = lvl_s2_q[0];
    assign auto_lf = lvl_s2_q[1];

    // movement decode
    logic col_at_max;
    logic col_at_zero;
    logic last_access;
    logic col_up;
    logic col_dn;
    logic adv_req;
    logic row_up;
    logic row_dn;
    logic mod_up;
    logic mod_dn;
    logic load_any;

    assign load_any    = ev[cat_pkg::EV_HOME] | ev[cat_pkg::EV_XLD] |
                         ev[cat_pkg::EV_YLD];
    assign col_at_max  = (addr_tens_q == cat_pkg::TENS_MAX) &&
                         (addr_units_q == cat_pkg::UNITS_MAX);
    assign col_at_zero = (addr_tens_q == cat_pkg::TENS_RST) &&
                         (addr_units_q == cat_pkg::UNITS_RST);
    assign last_access = ev[cat_pkg::EV_ACC] & col_at_max;
    // access steps forward as well
    assign col_up = ~load_any & (ev[cat_pkg::EV_FWD] |
                    ev[cat_pkg::EV_ACC]) & ~ev[cat_pkg::EV_BACK];
    assign col_dn = ~load_any & ev[cat_pkg::EV_BACK] &
                    ~(ev[cat_pkg::EV_FWD] | ev[cat_pkg::EV_ACC]);
    // line advance sources; auto feed rides on the column wrap
    assign adv_req = ev[cat_pkg::EV_ADV] | ev[cat_pkg::EV_DOWN] |
                     ev[cat_pkg::EV_LF] |
                     (last_access & auto_lf & ~col_up);
    assign row_up  = ~load_any & ((col_up & col_at_max) | adv_req) &
                     ~(ev[cat_pkg::EV_UP] | (col_dn & col_at_zero));
    assign row_dn  = ~load_any & ((col_dn & col_at_zero) |
                     ev[cat_pkg::EV_UP]) &
                     ~((col_up & col_at_max) | adv_req);
    assign mod_up  = row_up & (addr_row_q == cat_pkg::ROW_MAX);
    assign mod_dn  = row_dn & (addr_row_q == cat_pkg::ROW_RST);

    // illegal state timers, held then cleared
    logic [cat_pkg::FIX_CNT_W-1:0] units_fix_q;
    logic [cat_pkg::FIX_CNT_W-1:0] mod_fix_q;
    logic                          units_bad;
    logic                          mod_bad;
    logic                          units_clr;
    logic                          mod_clr;

    assign units_bad = addr_units_q > cat_pkg::UNITS_MAX;
    assign mod_bad   = addr_module_q == cat_pkg::MOD_BAD;
    assign units_clr = units_bad && (units_fix_q == cat_pkg::FIX_LIMIT);
    assign mod_clr   = mod_bad && (mod_fix_q == cat_pkg::FIX_LIMIT);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            units_fix_q <= '0;
            mod_fix_q   <= '0;
        end else begin
            units_fix_q <= (units_bad && !units_clr) ?
                           units_fix_q + 3'h1 : '0;
            mod_fix_q   <= (mod_bad && !mod_clr) ?
                           mod_fix_q + 3'h1 : '0;
        end
    end

    // column counter: units digit then three binary tens bits
    always_ff @(posedge core_clk) begin
        if (reset || ev[cat_pkg::EV_HOME]) begin
            addr_units_q <= cat_pkg::UNITS_RST;
            addr_tens_q  <= cat_pkg::TENS_RST;
        end else if (ev[cat_pkg::EV_XLD]) begin
            addr_units_q <= ld_s2_q[cat_pkg::LD_UNITS_LSB +: 4];
            addr_tens_q  <= ld_s2_q[cat_pkg::LD_TENS_LSB +: 3];
        end else if (units_clr) begin
            addr_units_q <= cat_pkg::UNITS_RST;
        end else if (col_up) begin
            if (addr_units_q == cat_pkg::UNITS_MAX) begin
                addr_units_q <= cat_pkg::UNITS_RST;
                addr_tens_q  <= addr_tens_q + 3'h1;
            end else begin
                addr_units_q <= addr_units_q + 4'h1;
            end
        end else if (col_dn) begin
            if (addr_units_q == cat_pkg::UNITS_RST) begin
                addr_units_q <= cat_pkg::UNITS_MAX;
                addr_tens_q  <= addr_tens_q - 3'h1;
            end else begin
                addr_units_q <= addr_units_q - 4'h1;
            end
        end
    end

    // row and module counters
    always_ff @(posedge core_clk) begin
        if (reset || ev[cat_pkg::EV_HOME]) begin
            addr_row_q    <= cat_pkg::ROW_RST;
            addr_module_q <= cat_pkg::MOD_RST;
        end else if (ev[cat_pkg::EV_YLD]) begin
            addr_row_q    <= ld_s2_q[cat_pkg::LD_ROW_LSB +: 3];
            addr_module_q <= ld_s2_q[cat_pkg::LD_MOD_LSB +: 2];
        end else begin
            if (row_up) begin
                addr_row_q <= addr_row_q + 3'h1;
            end else if (row_dn) begin
                addr_row_q <= addr_row_q - 3'h1;
            end
            if (mod_clr) begin
                addr_module_q <= cat_pkg::MOD_RST;
            end else if (mod_up) begin
                addr_module_q <= (addr_module_q == cat_pkg::MOD_LAST) ?
                                 cat_pkg::MOD_RST :
                                 addr_module_q + 2'h1;
            end else if (mod_dn) begin
                addr_module_q <= (addr_module_q == cat_pkg::MOD_RST) ?
                                 cat_pkg::MOD_LAST :
                                 addr_module_q - 2'h1;
            end
        end
    end

    // carry and advance indications
    always_ff @(posedge core_clk) begin
        if (reset) begin
            row_carry_up_q       <= 1'b0;
            line_advance_pulse_q <= 1'b0;
            final_row_flag_q     <= 1'b0;
        end else begin
            row_carry_up_q       <= col_up & col_at_max & row_up;
            line_advance_pulse_q <= ~load_any & (adv_req |
                                    (last_access & auto_lf));
            final_row_flag_q     <= (addr_module_q == cat_pkg::MOD_LAST) &&
                                    (addr_row_q == cat_pkg::ROW_MAX);
        end
    end

    // tracking counter follows each memory shift pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            trk_units_q <= cat_pkg::UNITS_RST;
            trk_tens_q  <= cat_pkg::TENS_RST;
            trk_row_q   <= cat_pkg::ROW_RST;
        end else if (ev[cat_pkg::EV_SHIFT]) begin
            if (trk_units_q >= cat_pkg::UNITS_MAX) begin
                trk_units_q <= cat_pkg::UNITS_RST;
                trk_tens_q  <= trk_tens_q + 3'h1;
                if (trk_tens_q == cat_pkg::TENS_MAX) begin
                    trk_row_q <= trk_row_q + 3'h1;
                end
            end else begin
                trk_units_q <= trk_units_q + 4'h1;
            end
        end
    end

    // gated comparisons, registered for clean pulses
    logic col_eq;
    logic row_eq;

    assign col_eq = gate_ok && (addr_units_q == trk_units_q) &&
                    (addr_tens_q == trk_tens_q);
    assign row_eq = addr_row_q == trk_row_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            column_match_q   <= 1'b0;
            position_match_q <= 1'b0;
            cursor_q         <= 1'b0;
        end else begin
            column_match_q   <= col_eq;
            position_match_q <= col_eq & row_eq;
            cursor_q         <= col_eq & row_eq &&
                                (scan_s2_q == cat_pkg::CURSOR_SCAN);
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_UNITS_FIX: assert property (
        units_bad |-> ##[1:5] !units_bad)
        else $error("units digit stayed above nine");

    AST_MODULE_FIX: assert property (
        mod_bad |-> ##[1:5] !mod_bad)
        else $error("module counter stayed in state three");

    AST_FWD_STEP: assert property (
        (col_up && !col_at_max && !units_bad && !units_clr) |=>
        col_index(addr_tens_q, addr_units_q) ==
        7'($past(col_index(addr_tens_q, addr_units_q)) + 7'h01))
        else $error("forward step did not add one column");

    AST_CARRY_WRAP: assert property (
        row_carry_up_q |-> col_at_zero &&
        addr_row_q == 3'($past(addr_row_q, 1) + 3'h1))
        else $error("row carry without column wrap and row step");

    AST_BACK_WRAP: assert property (
        (col_dn && col_at_zero && !ev[cat_pkg::EV_UP] && !adv_req) |=>
        col_at_max && addr_row_q == 3'($past(addr_row_q) - 3'h1))
        else $error("down count at column zero missed row");

    AST_MODULE_STEP: assert property (
        (mod_up && !mod_bad) |=> addr_module_q != $past(addr_module_q) &&
        addr_row_q == cat_pkg::ROW_RST)
        else $error("row wrap did not move module");

    AST_TRACK: assert property (
        !ev[cat_pkg::EV_SHIFT] |=> $stable(trk_units_q) && $stable(trk_row_q))
        else $error("tracking moved without a shift pulse");

    AST_GATE: assert property (
        !gate_ok |=> !column_match_q && !position_match_q)
        else $error("match raised while compare gate low");

    AST_FINAL: assert property (
        final_row_flag_q |-> $past(addr_module_q) == cat_pkg::MOD_LAST &&
        $past(addr_row_q) == cat_pkg::ROW_MAX)
        else $error("final row flag without last row");

    AST_CURSOR: assert property (
        cursor_q |-> position_match_q &&
        $past(scan_s2_q) == cat_pkg::CURSOR_SCAN)
        else $error("cursor outside scan line eight or match");

    AST_RESET: assert property (
        disable iff (1'b0) reset |=> !position_match_q && !cursor_q &&
        addr_module_q == cat_pkg::MOD_RST)
        else $error("reset left outputs set");
endmodule
`default_nettype wire

//--- cat_shift_model.sv
// memory shift control model: bursts of shifts with line-end pauses
`timescale 1ns/1ps
`default_nettype none
module cat_shift_model #(
    parameter int CHAR_CYC = 6
) (
    input  wire logic       core_clk,
    input  wire integer     limit,
    output logic            mem_shift,
    output logic            compare_gate,
    output logic [3:0]      scan_line,
    output int              shifts
);
    int n;
    // one burst per scan line while shifts remain below limit
    initial begin
        mem_shift = 1'b0;
        compare_gate = 1'b0;
        scan_line = 4'h0;
        shifts = 0;
        forever begin
            @(negedge core_clk);
            if (shifts < limit) begin
                compare_gate = 1'b1;
                // 80 shifts per burst, one per character time
                for (n = 0; n < 80 && shifts < limit; n++) begin
                    mem_shift = 1'b1;
                    repeat (CHAR_CYC / 2) @(negedge core_clk);
                    mem_shift = 1'b0;
                    shifts++;
                    repeat (CHAR_CYC - CHAR_CYC / 2) @(negedge core_clk);
                end
                // pause of 20 character times, gate low
                compare_gate = 1'b0;
                repeat (20 * CHAR_CYC) @(negedge core_clk);
                scan_line = (scan_line == 4'h8) ? 4'h0 : scan_line + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
// testbench for the cursor address tracker
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                          core_clk;
    logic                          reset;
    logic [9:0]                    pins;
    logic [cat_pkg::LOAD_W-1:0]    load_data;
    logic                          auto_lf;
    logic                          mem_shift;
    logic                          compare_gate;
    logic [cat_pkg::SCAN_W-1:0]    scan_line;
    logic [cat_pkg::UNITS_W-1:0]   a_units, t_units;
    logic [cat_pkg::TENS_W-1:0]    a_tens, t_tens;
    logic [cat_pkg::ROW_W-1:0]     a_row, t_row;
    logic [cat_pkg::MOD_W-1:0]     a_mod;
    logic                          col_m, pos_m, cur, last_row, carry, lfp;
    logic                          col_m_d, pos_m_d, cur_d;
    int                            limit, shifts, errors, samples_checked;
    int                            cm_cnt, pm_cnt, cur_cnt, carry_cnt, lf_cnt;
    int                            base;

    // bits 0-5 are active low, 6-9 active high
    localparam logic [9:0] IDLE = 10'h03f;

    cat_tracker u_dut (
        .core_clk(core_clk), .reset(reset),
        .cursor_step_forward_n(pins[0]), .cursor_step_back_n(pins[1]),
        .cursor_step_up_n(pins[2]), .line_advance_n(pins[3]),
        .column_load_strobe_n(pins[4]), .row_load_strobe_n(pins[5]),
        .home(pins[6]), .mem_access(pins[7]), .cursor_down(pins[8]),
        .line_feed(pins[9]), .load_data(load_data), .auto_lf_mode(auto_lf),
        .mem_shift(mem_shift), .compare_gate(compare_gate),
        .scan_line(scan_line), .addr_units_q(a_units), .addr_tens_q(a_tens),
        .addr_row_q(a_row), .addr_module_q(a_mod), .trk_units_q(t_units),
        .trk_tens_q(t_tens), .trk_row_q(t_row), .column_match_q(col_m),
        .position_match_q(pos_m), .cursor_q(cur),
        .final_row_flag_q(last_row), .row_carry_up_q(carry),
        .line_advance_pulse_q(lfp)
    );

    cat_shift_model u_shift (
        .core_clk(core_clk), .limit(limit), .mem_shift(mem_shift),
        .compare_gate(compare_gate), .scan_line(scan_line), .shifts(shifts)
    );

    // clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // count pulses and rising edges of outputs, sampled mid-cycle
    always @(negedge core_clk) begin
        if (col_m === 1'b1 && col_m_d !== 1'b1) cm_cnt++;
        if (pos_m === 1'b1 && pos_m_d !== 1'b1) pm_cnt++;
        if (cur === 1'b1 && cur_d !== 1'b1) cur_cnt++;
        if (carry === 1'b1) carry_cnt++;
        if (lfp === 1'b1) lf_cnt++;
        col_m_d = col_m;
        pos_m_d = pos_m;
        cur_d = cur;
    end

    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one pulse of a pin, then time for sync, action and settle
    task automatic hit(input int b);
        @(negedge core_clk);
        pins[b] = ~pins[b];
        @(negedge core_clk);
        pins[b] = ~pins[b];
        repeat (6) @(negedge core_clk);
    endtask

    task automatic chk_addr(input int col, input int row, input int md);
        chk("units", 16'(a_units), 16'(col % 10));
        chk("tens", 16'(a_tens), 16'(col / 10));
        chk("row", 16'(a_row), 16'(row));
        chk("module", 16'(a_mod), 16'(md));
    endtask

    task automatic load(input int b, input logic [6:0] d);
        @(negedge core_clk);
        load_data = d;
        hit(b);
    endtask

    initial begin
        {errors, samples_checked, cm_cnt, pm_cnt, cur_cnt} = '0;
        {carry_cnt, lf_cnt, limit} = '0;
        {col_m_d, pos_m_d, cur_d} = 3'h0;
        reset = 1'b1;
        pins = IDLE;
        load_data = 7'h00;
        auto_lf = 1'b0;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        // reset state
        chk_addr(0, 0, 0);
        chk("trk", 16'({t_row, t_tens, t_units}), 16'h0000);
        chk("matches", 16'({col_m, pos_m, cur, carry}), 16'h0000);
        // direct load to last position of last module
        load(4, 7'h79);
        load(5, 7'h17);
        chk_addr(79, 7, 2);
        chk("final_row", 16'(last_row), 16'h0001);
        // step forward wraps column, row and module
        hit(0);
        chk_addr(0, 0, 0);
        chk("carry", 16'(carry_cnt), 16'h0001);
        chk("final_row", 16'(last_row), 16'h0000);
        hit(1);
        chk_addr(79, 7, 2);
        hit(2);
        chk_addr(79, 6, 2);
        hit(3);
        chk_addr(79, 7, 2);
        base = lf_cnt;
        hit(8);
        chk_addr(79, 0, 0);
        hit(9);
        chk_addr(79, 1, 0);
        chk("lf_pulses", 16'(lf_cnt - base), 16'h0002);
        // access steps forward, wrapping the line
        hit(7);
        chk_addr(0, 2, 0);
        chk("carry", 16'(carry_cnt), 16'h0002);
        // access at last column with automatic line feed
        auto_lf = 1'b1;
        load(4, 7'h79);
        base = lf_cnt;
        hit(7);
        chk_addr(0, 3, 0);
        chk("lf_pulses", 16'(lf_cnt - base), 16'h0001);
        auto_lf = 1'b0;
        // illegal units digit and module three are cleared
        load(4, 7'h3c);
        load(5, 7'h1b);
        repeat (8) @(negedge core_clk);
        chk_addr(30, 3, 0);
        hit(6);
        chk_addr(0, 0, 0);
        // shift run: address column 5 row 0 against tracking
        load(4, 7'h05);
        limit = 660;
        for (int i = 0; i < 20000 && shifts < limit; i++) begin
            @(negedge core_clk);
        end
        if (shifts < limit) begin
            errors++; // shift run timed out, counted as a mismatch
        end
        repeat (10) @(negedge core_clk);
        chk("trk_units", 16'(t_units), 16'h0000);
        chk("trk_tens", 16'(t_tens), 16'h0002);
        chk("trk_row", 16'(t_row), 16'h0000);
        chk("col_matches", 16'(cm_cnt), 16'h0009);
        chk("pos_matches", 16'(pm_cnt), 16'h0002);
        chk("cursors", 16'(cur_cnt), 16'h0001);
        end_of_test();
    end
endmodule
`default_nettype wire
